// ==== efl_framer.sv ====
// Embedded-clock display link framer: transmit framing and receive alignment.
// Assumes pixel clock and data pins are asynchronous to CLK_IN and far slower;
// software drives a plain register port in the CLK_IN domain.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "efl_cfg.svh"

// Operation
// - Frame is 28 bits, 24 data
// - Clock bits fixed one then zero
// - One frame per pixel clock period
// - Word: 18 colour, 3 strobes, 3 spare
// - Control bits carry coding and mode
// - Balance and scramble data; receiver inverts
// - Sync strobes carried and reproduced
// - Align from stream alone, hot plug
// - Lock output shows link status
// - Emphasis only on changed bits
// - Swing select drives output amplitude
module efl_framer
	import efl_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic PIX_CLK_IN,
	input wire logic SWING_SEL_IN,
	input wire logic [`EFL_DATA_W-1:0] TX_WORD_IN,
	input wire logic [`EFL_FRAME_W-1:0] RX_FRAME_IN,
	input wire logic [`EFL_ADDR_W-1:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [`EFL_FRAME_W-1:0] TX_FRAME_OUT,
	output logic TX_FRAME_STB_OUT,
	output logic [`EFL_FRAME_W-1:0] TX_EMPH_OUT,
	output logic TX_SWING_OUT,
	output logic [`EFL_DATA_W-1:0] RX_WORD_OUT,
	output logic RX_WORD_STB_OUT,
	output logic RX_LOCKED_OUT,
	output logic [31:0] RDATA_OUT,
	output logic IRQ_OUT
);

	localparam int SYNC_W = `EFL_FRAME_W + `EFL_DATA_W + 2;
	// Reset image of the state
	localparam efl_state_t EFL_RST = '{
		rx_state: EFL_RX_HUNT,
		ctrl: efl_ctrl_t'(`EFL_CTRL_RST),
		mask: `EFL_MASK_RST,
		default: '0
	};

	efl_state_t r; // Registered state
	efl_state_t next_r; // Next state

	logic [SYNC_W-1:0] pins_sync; // Synchronised pins
	logic pix_fall; // Middle of pixel period
	logic swing_s; // Synced swing select
	efl_word_t tx_word_s; // Synced transmit word
	logic [`EFL_FRAME_W-1:0] rx_in_s; // Synced received frame
	logic [`EFL_DATA_W-1:0] enc_data; // Encoded payload
	logic enc_inv; // Encode inverted flag
	efl_frame_t tx_next; // Frame being built
	logic [`EFL_FRAME_W-1:0] tx_vec; // Frame as bits
	logic [`EFL_WIN_W-1:0] win; // Two frames of stream
	logic [`EFL_WIN_W-1:0] win_sh; // Window at chosen offset
	efl_frame_t rx_al; // Aligned received frame
	logic [`EFL_FRAME_W-1:0] cand; // Edge found per offset
	logic hunt_hit; // Some offset has the edge
	logic [`EFL_OFF_W-1:0] hunt_off; // Lowest such offset
	logic [`EFL_DATA_W-1:0] dec_data; // Decoded payload
	logic [`EFL_EVT_W-1:0] evt; // Events this cycle
	logic rd_status; // Status read clears

	////////////////////////////////////////////////////////////////
	// Pin synchronisers, pixel clock in bit 0
	efl_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_in(SYS_RST_IN),
		.pins_in({RX_FRAME_IN, TX_WORD_IN, SWING_SEL_IN, PIX_CLK_IN}),
		.sync_out(pins_sync),
		.fall_out(pix_fall)
	);

	assign swing_s = pins_sync[1];
	assign tx_word_s = efl_word_t'(pins_sync[`EFL_DATA_W+1:2]);
	assign rx_in_s = pins_sync[SYNC_W-1:`EFL_DATA_W+2];

	////////////////////////////////////////////////////////////////
	// Transmit payload conditioning
	efl_codec #(
		.DECODE(1'b0)
	) u_enc (
		.data_in(tx_word_s),
		.scr_en_in(r.ctrl.scr_en),
		.inv_in(1'b0),
		.data_out(enc_data),
		.inv_out(enc_inv)
	);

	// Frame assembly, clock high first and clock low last
	always_comb
	begin
		tx_next.clock_high_bit = 1'b1;
		tx_next.data = enc_data;
		tx_next.link_control_bit_a = enc_inv;
		tx_next.link_control_bit_b = r.ctrl.scr_en;
		tx_next.clock_low_bit = 1'b0;
		tx_vec = tx_next;
	end

	////////////////////////////////////////////////////////////////
	// Receive alignment search over two frames of stream
	assign win = {r.rx_prev, rx_in_s};

	// Offset k holds a frame when clock high leads and clock low trails
	for (genvar k = 0; k < `EFL_FRAME_W; k++)
	begin : g_cand
		assign cand[k] = win[`EFL_WIN_W-1-k] & ~win[`EFL_FRAME_W-k];
	end

	// Pick the lowest offset with the edge
	always_comb
	begin
		hunt_hit = |cand;
		hunt_off = '0;
		for (int k = `EFL_FRAME_W - 1; k >= 0; k--)
		begin
			if (cand[k])
			begin
				hunt_off = `EFL_OFF_W'(k);
			end
		end
	end

	assign win_sh = win << r.rx_off;
	assign rx_al = efl_frame_t'(win_sh[`EFL_WIN_W-1:`EFL_FRAME_W]);

	// Receive payload recovery
	efl_codec #(
		.DECODE(1'b1)
	) u_dec (
		.data_in(rx_al.data),
		.scr_en_in(rx_al.link_control_bit_b),
		.inv_in(rx_al.link_control_bit_a),
		.data_out(dec_data),
		.inv_out()
	);

	assign rd_status = RD_IN && (ADDR_IN == `EFL_REG_STATUS);

	////////////////////////////////////////////////////////////////
	// Next state of the whole framer
	always_comb
	begin
		next_r = r;
		evt = '0;
		next_r.tx_stb = 1'b0;
		next_r.rx_stb = 1'b0;
		next_r.swing = swing_s;
		// Transmit: one frame per pixel period
		if (pix_fall)
		begin
			next_r.tx_frame = tx_next;
			next_r.tx_stb = 1'b1;
			// Extra drive only where a bit differs from the one before
			if (r.ctrl.emph_en)
			begin
				next_r.tx_emph = tx_vec ^ {r.tx_frame.clock_low_bit, tx_vec[`EFL_FRAME_W-1:1]};
			end
			else
			begin
				next_r.tx_emph = '0;
			end
		end
		// Receive: one step per pixel period
		if (pix_fall)
		begin
			next_r.rx_prev = rx_in_s;
			case (r.rx_state)
				EFL_RX_HUNT:
				begin
					// Any edge starts a trial, no training needed
					if (hunt_hit)
					begin
						next_r.rx_off = hunt_off;
						next_r.rx_cnt = 3'h1;
						next_r.rx_state = EFL_RX_VERIFY;
					end
				end
				EFL_RX_VERIFY:
				begin
					// Same position again in the next frame
					if (cand[r.rx_off])
					begin
						next_r.rx_cnt = r.rx_cnt + 3'h1;
						if (r.rx_cnt == `EFL_LOCK_FRAMES - 3'h1)
						begin
							next_r.rx_state = EFL_RX_LOCKED;
							next_r.locked = 1'b1;
							evt[`EFL_EVT_GAIN] = 1'b1;
						end
					end
					else
					begin
						next_r.rx_state = EFL_RX_HUNT;
						evt[`EFL_EVT_ALIGN] = 1'b1;
					end
				end
				EFL_RX_LOCKED:
				begin
					// Deliver the word, or drop lock on a missed edge
					if (cand[r.rx_off])
					begin
						next_r.rx_word = efl_word_t'(dec_data);
						next_r.rx_stb = 1'b1;
					end
					else
					begin
						next_r.rx_state = EFL_RX_HUNT;
						next_r.locked = 1'b0;
						evt[`EFL_EVT_LOST] = 1'b1;
					end
				end
				default:
				begin
					next_r.rx_state = EFL_RX_HUNT;
					next_r.locked = 1'b0;
				end
			endcase
		end
		// Register writes
		if (WR_IN && (ADDR_IN == `EFL_REG_CTRL))
		begin
			next_r.ctrl = efl_ctrl_t'(WDATA_IN[1:0]);
		end
		if (WR_IN && (ADDR_IN == `EFL_REG_MASK))
		begin
			next_r.mask = WDATA_IN[`EFL_EVT_W-1:0];
		end
		// Read data for the next cycle only
		next_r.rdata = '0;
		if (RD_IN)
		begin
			case (ADDR_IN)
				`EFL_REG_CTRL: next_r.rdata = 32'(r.ctrl);
				`EFL_REG_STATUS: next_r.rdata = 32'(r.status);
				`EFL_REG_MASK: next_r.rdata = 32'(r.mask);
				`EFL_REG_STATE: next_r.rdata = 32'({r.rx_off, r.rx_state, r.locked});
				default: next_r.rdata = '0;
			endcase
		end
		// Sticky status: read clears, a new event wins
		next_r.status = (rd_status ? '0 : r.status) | evt;
		next_r.irq = |(next_r.status & next_r.mask);
	end

	// State registers
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			r <= EFL_RST;
		end
		else
		begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs straight from the state
	assign TX_FRAME_OUT = r.tx_frame;
	assign TX_FRAME_STB_OUT = r.tx_stb;
	assign TX_EMPH_OUT = r.tx_emph;
	assign TX_SWING_OUT = r.swing;
	assign RX_WORD_OUT = r.rx_word;
	assign RX_WORD_STB_OUT = r.rx_stb;
	assign RX_LOCKED_OUT = r.locked;
	assign RDATA_OUT = r.rdata;
	assign IRQ_OUT = r.irq;

	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_pix_frame;
		pix_fall ##1 TX_FRAME_STB_OUT;
	endsequence

	sequence s_stb_gap;
		!TX_FRAME_STB_OUT [*2];
	endsequence

	AST_TX_CLOCK_BITS: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		TX_FRAME_STB_OUT |-> TX_FRAME_OUT[`EFL_FRAME_W-1] && !TX_FRAME_OUT[0])
		else $error("clock bits wrong in frame");

	AST_TX_ONE_PER_PIX: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		s_pix_frame |=> s_stb_gap)
		else $error("frame strobe not single per pixel period");

	AST_TX_BALANCE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		TX_FRAME_STB_OUT |-> $countones(TX_FRAME_OUT[`EFL_FRAME_W-2:3]) <= 12)
		else $error("payload not balanced");

	AST_TX_MODE_BIT: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		pix_fall |=> TX_FRAME_OUT[1] == $past(r.ctrl.scr_en))
		else $error("mode bit does not follow control");

	AST_TX_EMPH: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		TX_FRAME_STB_OUT |-> (TX_EMPH_OUT & ~(TX_FRAME_OUT ^ {1'b0, TX_FRAME_OUT[`EFL_FRAME_W-1:1]})) == '0)
		else $error("emphasis on a repeated bit");

	AST_SWING: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		##1 TX_SWING_OUT == $past(swing_s))
		else $error("swing output lags select");

	AST_LOCK_AFTER_N: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		$rose(RX_LOCKED_OUT) |-> $past(r.rx_state) == EFL_RX_VERIFY && $past(r.rx_cnt) == 3'h3)
		else $error("lock without enough frames");

	AST_LOCK_DROP: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		RX_LOCKED_OUT && pix_fall && !cand[r.rx_off] |=> !RX_LOCKED_OUT ##1 !RX_WORD_STB_OUT)
		else $error("lock held over a missed edge");

	AST_RX_ONLY_LOCKED: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		RX_WORD_STB_OUT |-> RX_LOCKED_OUT && $past(cand[r.rx_off]))
		else $error("word delivered without lock");

	AST_IRQ: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		IRQ_OUT == |(r.status & r.mask))
		else $error("interrupt disagrees with status");

endmodule : efl_framer

`default_nettype wire

// ==== efl_cfg.svh ====
// Constants of the embedded-clock display link framer.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef EFL_CFG_SVH
`define EFL_CFG_SVH

// Frame and word geometry
`define EFL_FRAME_W 28
`define EFL_DATA_W 24
`define EFL_COLOR_W 18
`define EFL_GP_W 3
`define EFL_OFF_W 5
`define EFL_WIN_W 56

// Balance limit: more ones than this inverts the word
`define EFL_BAL_LIMIT 5'h0C
// Scramble pattern applied when scrambling is on
`define EFL_SCR_PATTERN 24'h5AC396
// Consecutive good frames before lock
`define EFL_LOCK_FRAMES 3'h4

// Register offsets
`define EFL_ADDR_W 4
`define EFL_REG_CTRL 4'h0
`define EFL_REG_STATUS 4'h4
`define EFL_REG_MASK 4'h8
`define EFL_REG_STATE 4'hC

// Reset values
`define EFL_CTRL_RST 2'h1
`define EFL_MASK_RST 3'h0

// Event bit positions
`define EFL_EVT_W 3
`define EFL_EVT_GAIN 0
`define EFL_EVT_LOST 1
`define EFL_EVT_ALIGN 2

`endif

// ==== efl_pkg.sv ====
// Types shared by the framer modules.
// Assumes efl_cfg.svh is reachable by bare name.
`include "efl_cfg.svh"

package efl_pkg;

	// Parallel user word, colour in the low bits
	typedef struct packed {
		logic [`EFL_GP_W-1:0] gp;
		logic active_video;
		logic vertical_sync;
		logic horizontal_sync;
		logic [`EFL_COLOR_W-1:0] color;
	} efl_word_t;

	// Serial frame, most significant bit sent first
	typedef struct packed {
		logic clock_high_bit;
		logic [`EFL_DATA_W-1:0] data;
		logic link_control_bit_a;
		logic link_control_bit_b;
		logic clock_low_bit;
	} efl_frame_t;

	// Receive alignment states
	typedef enum logic [2:0] {
		EFL_RX_HUNT = 3'b001,
		EFL_RX_VERIFY = 3'b010,
		EFL_RX_LOCKED = 3'b100
	} efl_rx_state_t;

	// Control register
	typedef struct packed {
		logic emph_en;
		logic scr_en;
	} efl_ctrl_t;

	// Whole state of the framer
	typedef struct packed {
		efl_frame_t tx_frame;
		logic [`EFL_FRAME_W-1:0] tx_emph;
		logic tx_stb;
		logic swing;
		logic [`EFL_FRAME_W-1:0] rx_prev;
		logic [`EFL_OFF_W-1:0] rx_off;
		efl_rx_state_t rx_state;
		logic [2:0] rx_cnt;
		efl_word_t rx_word;
		logic rx_stb;
		logic locked;
		efl_ctrl_t ctrl;
		logic [`EFL_EVT_W-1:0] status;
		logic [`EFL_EVT_W-1:0] mask;
		logic [31:0] rdata;
		logic irq;
	} efl_state_t;

endpackage : efl_pkg

// ==== efl_sync.sv ====
// Two-stage synchroniser for pins, with a falling-edge pulse on bit 0.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none

module efl_sync
	import efl_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] pins_in,
	output logic [W-1:0] sync_out,
	output logic fall_out
);

	// Synchroniser state
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic last0;
	} efl_sync_state_t;

	efl_sync_state_t r; // Registered state
	efl_sync_state_t next_r; // Next state

	////////////////////////////////////////////////////////////////
	// Next state: first stage feeds only the second
	always_comb
	begin
		next_r = r;
		next_r.meta = pins_in;
		next_r.sync = r.meta;
		next_r.last0 = r.sync[0];
	end

	// State registers
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign sync_out = r.sync;
	assign fall_out = r.last0 & ~r.sync[0];

endmodule : efl_sync

`default_nettype wire

// ==== efl_codec.sv ====
// Payload balance and scramble codec, encode or decode by parameter.
// Assumes the caller registers the outputs.
`timescale 1ns/100ps
`default_nettype none
`include "efl_cfg.svh"

module efl_codec
	import efl_pkg::*;
#(
	parameter bit DECODE = 1'b0
)
(
	input wire logic [`EFL_DATA_W-1:0] data_in,
	input wire logic scr_en_in,
	input wire logic inv_in,
	output logic [`EFL_DATA_W-1:0] data_out,
	output logic inv_out
);

	logic [`EFL_DATA_W-1:0] scr_mask; // Scramble mask
	logic [`EFL_DATA_W-1:0] scrambled; // Encode: after scramble
	logic [4:0] ones [`EFL_DATA_W:0]; // Running count of ones

	assign scr_mask = scr_en_in ? `EFL_SCR_PATTERN : '0;
	assign scrambled = data_in ^ scr_mask;
	assign ones[0] = 5'h00;

	// Count ones of the scrambled word
	for (genvar i = 0; i < `EFL_DATA_W; i++)
	begin : g_count
		assign ones[i+1] = ones[i] + {4'h0, scrambled[i]};
	end

	////////////////////////////////////////////////////////////////
	// Encode inverts heavy words; decode undoes both steps
	always_comb
	begin
		if (DECODE)
		begin
			inv_out = inv_in;
			data_out = (inv_in ? ~data_in : data_in) ^ scr_mask;
		end
		else
		begin
			inv_out = ones[`EFL_DATA_W] > `EFL_BAL_LIMIT;
			data_out = inv_out ? ~scrambled : scrambled;
		end
	end

endmodule : efl_codec

`default_nettype wire

// ==== efl_link_model.sv ====
// Far-end serializer model: turns a user word into one rotated line frame.
// Assumes the bench runs its pixel clock and holds the rotation steady.
`timescale 1ns/100ps
`default_nettype none
`include "efl_cfg.svh"

module efl_link_model
	import efl_pkg::*;
(
	input wire logic pix_clk_in,
	input wire logic [`EFL_DATA_W-1:0] word_in,
	input wire logic scr_in,
	input wire logic bad_in,
	input wire logic [4:0] rot_in,
	output logic [`EFL_FRAME_W-1:0] frame_out
);

	////////////////////////////////////////////////////////////////////////
	// Encode one word: scramble, balance, then wrap with clock bits
	function automatic logic [`EFL_FRAME_W-1:0] enc(input logic [`EFL_DATA_W-1:0] w, input logic s);
		logic [`EFL_DATA_W-1:0] d;
		logic inv;
		d = w ^ (s ? `EFL_SCR_PATTERN : 24'h000000);
		inv = ($countones(d) > 12);
		if (inv)
		begin
			d = ~d;
		end
		return {1'b1, d, inv, s, 1'b0};
	endfunction : enc

	////////////////////////////////////////////////////////////////////////
	// Rotated stream view of the frame, as the line would deliver it
	logic [2*`EFL_FRAME_W-1:0] two;
	logic [`EFL_FRAME_W-1:0] f; // Frame before rotation
	logic [`EFL_FRAME_W-1:0] on_line = 28'h0000000; // Quiet line until the first pixel period

	// One frame per pixel period; a bad frame loses its clock-high bit before rotation
	always @(posedge pix_clk_in)
	begin
		f = enc(word_in, scr_in);
		f[`EFL_FRAME_W-1] = f[`EFL_FRAME_W-1] & ~bad_in;
		two = {f, f} << rot_in;
		on_line <= two[55:28];
	end

	assign frame_out = on_line;

endmodule : efl_link_model
`default_nettype wire

// ==== efl_tb.sv ====
// Self-checking bench for the framer: register port, transmit and receive.
// Assumes the link model stands in for the far end of the line.
`timescale 1ns/100ps
`default_nettype none
`include "efl_cfg.svh"

module tb
	import efl_pkg::*;
;
	logic clk, rst, pix, swing, wr, rd, m_scr, m_bad;
	logic [3:0] addr;
	logic [31:0] wdata, d;
	logic [23:0] tx_word, m_word;
	logic [27:0] rx_frame, tx_frame, tx_emph, ef;
	logic [23:0] rx_word;
	logic tx_stb, tx_swing, rx_stb, locked, irq;
	logic [31:0] rdata;
	int fail_count, num_checks;

	efl_framer uut (.CLK_IN(clk), .SYS_RST_IN(rst), .PIX_CLK_IN(pix), .SWING_SEL_IN(swing),
		.TX_WORD_IN(tx_word), .RX_FRAME_IN(rx_frame), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .TX_FRAME_OUT(tx_frame), .TX_FRAME_STB_OUT(tx_stb),
		.TX_EMPH_OUT(tx_emph), .TX_SWING_OUT(tx_swing), .RX_WORD_OUT(rx_word),
		.RX_WORD_STB_OUT(rx_stb), .RX_LOCKED_OUT(locked), .RDATA_OUT(rdata), .IRQ_OUT(irq));
	efl_link_model link (.pix_clk_in(pix), .word_in(m_word), .scr_in(m_scr), .bad_in(m_bad),
		.rot_in(5'h09), .frame_out(rx_frame));

	////////////////////////////////////////////////////////////////////////
	// System clock 4 ns, pixel clock 32 ns with an unrelated phase
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		pix = 1'b0;
		#5;
		forever #16 pix = ~pix;
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// Compare a register word
	task chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk_reg

	// Compare a frame, emphasis or word bus
	task chk_bus(input logic [27:0] g, input logic [27:0] e, input string m);
		chk_reg({4'h0, g}, {4'h0, e}, m);
	endtask : chk_bus

	// Compare a single flag
	task chk_flag(input logic g, input logic e, input string m);
		chk_reg({31'h0, g}, {31'h0, e}, m);
	endtask : chk_flag

	// Wait for an output to reach a level, bounded
	task wait_sig(input int sel, input logic lvl, input int n);
		logic s;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			#1;
			s = (sel == 0) ? tx_stb : (sel == 1) ? rx_stb : locked;
			if (s === lvl)
				return;
		end
		fail_count++;
		$display("FAIL %0t wait timed out on %0d", $time, sel);
		report_and_stop();
	endtask : wait_sig

	// One-cycle register write
	task wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// One-cycle register read, data stands in the following cycle
	task rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	// Send a word and check the second frame built after it
	task tx_chk(input logic [23:0] w, input logic s, input logic e);
		@(posedge clk);
		tx_word <= w;
		wait_sig(0, 1'b1, 40);
		wait_sig(0, 1'b1, 40);
		ef = link.enc(w, s);
		chk_bus(tx_frame, ef, "tx frame");
		chk_bus(tx_emph, e ? {ef[27], ef[27:1] ^ ef[26:0]} : 28'h0, "emphasis");
	endtask : tx_chk

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{rst, swing, wr, rd, m_scr, m_bad} = 6'h20;
		{addr, wdata, tx_word, m_word} = '0;
		fail_count = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_reg(`EFL_REG_CTRL, d);
		chk_reg(d, 32'h00000001, "ctrl reset");
		rd_reg(4'h1, d);
		chk_reg(d, 32'h00000000, "unmapped read");
		// Transmit: scramble on, then plain with inversion, then emphasis
		tx_chk(24'h2C5A13, 1'b1, 1'b0);
		wr_reg(`EFL_REG_CTRL, 32'h00000000);
		tx_chk(24'hFFFFFF, 1'b0, 1'b0);
		wr_reg(`EFL_REG_CTRL, 32'h00000002);
		tx_chk(24'h1C0F0F, 1'b0, 1'b1);
		@(posedge clk);
		swing <= 1'b1;
		repeat (4) @(posedge clk);
		chk_flag(tx_swing, 1'b1, "swing high");
		// Receive: lock from the stream alone
		wait_sig(2, 1'b1, 400);
		rd_reg(`EFL_REG_STATE, d);
		chk_reg(d & 32'h000001FF, 32'h00000139, "locked state");
		wr_reg(`EFL_REG_MASK, 32'h00000007);
		#1;
		chk_flag(irq, 1'b1, "irq on gain");
		rd_reg(`EFL_REG_STATUS, d);
		chk_reg(d, 32'h00000001, "gain event");
		repeat (2) @(posedge clk);
		#1;
		chk_flag(irq, 1'b0, "irq after clear");
		// Recovered words, scrambled and inverted, sync strobes set
		for (int k = 0; k < 2; k++)
		begin
			m_word <= k ? 24'hFFFFFF : 24'h2C5A13;
			m_scr <= ~k[0];
			repeat (3) wait_sig(1, 1'b1, 40);
			chk_bus({4'h0, rx_word}, k ? 28'h0FFFFFF : 28'h02C5A13, "rx word");
		end
		// Broken clock edge drops lock, clean stream regains it
		m_bad <= 1'b1;
		wait_sig(2, 1'b0, 100);
		#1;
		chk_flag(irq, 1'b1, "irq on loss");
		rd_reg(`EFL_REG_STATUS, d);
		chk_reg(d & 32'h00000002, 32'h00000002, "lost event");
		m_bad <= 1'b0;
		m_word <= '0;
		wait_sig(2, 1'b1, 400);
		chk_flag(locked, 1'b1, "relock");
		rd_reg(`EFL_REG_STATE, d);
		chk_reg(d & 32'h000001FF, 32'h00000139, "relock offset");
		rd_reg(`EFL_REG_STATUS, d);
		chk_reg(d, 32'h00000005, "align and gain events");
		report_and_stop();
	end

endmodule : tb
`default_nettype wire
